//--- hw/tpc_pkg.sv
package tpc_pkg;

  // ==========================================================
  // Register port geometry
  localparam int AW = 4;
  localparam int DW = 16;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFF_PERIOD = 4'h0;
  localparam logic [3:0] OFF_DEAD = 4'h1;
  localparam logic [3:0] OFF_PDEL = 4'h2;
  localparam logic [3:0] OFF_DUTYA = 4'h3;
  localparam logic [3:0] OFF_DUTYB = 4'h4;
  localparam logic [3:0] OFF_DUTYC = 4'h5;
  localparam logic [3:0] OFF_SEG = 4'h6;
  localparam logic [3:0] OFF_GATE = 4'h7;
  localparam logic [3:0] OFF_MODE = 4'h8;
  localparam logic [3:0] OFF_SYNCW = 4'h9;
  localparam logic [3:0] OFF_SWTRIP = 4'hA;
  localparam logic [3:0] OFF_STATUS = 4'hB;
  localparam logic [3:0] OFF_CTRL = 4'hC;

  // ==========================================================
  // Field positions
  localparam int MODE_DOUBLE_BIT = 6;
  localparam int STAT_TRIP_BIT = 0;
  localparam int STAT_SHUT_BIT = 1;
  localparam int STAT_HALF_BIT = 3;
  localparam int SEG_XOVER_LSB = 6;
  localparam int GATE_HI_BIT = 8;
  localparam int GATE_LO_BIT = 9;
  localparam int CTRL_EN_BIT = 0;
  localparam int DEAD_W = 10;
  localparam int SEG_W = 9;
  localparam int GATE_W = 10;
  localparam int SYNCW_W = 8;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_PERIOD = 16'h03E8;
  localparam logic [15:0] RST_DEAD = 16'h0000;
  localparam logic [15:0] RST_PDEL = 16'h0000;
  localparam logic [15:0] RST_DUTY = 16'h0000;
  localparam logic [15:0] RST_SEG = 16'h003F;
  localparam logic [15:0] RST_GATE = 16'h0000;
  localparam logic [15:0] RST_SYNCW = 16'h0027;

  // ==========================================================
  // Working set latched on each sync rising edge
  typedef struct packed {
    logic [15:0] period;
    logic [DEAD_W-1:0] dead;
    logic [15:0] pdel;
    logic [SYNCW_W-1:0] syncw;
    logic [2:0][15:0] duty;
    logic [SEG_W-1:0] seg;
  } tpc_cfg_t;

endpackage

//--- hw/tpc_gate_chop.sv
`timescale 1ns/1ns
module tpc_gate_chop #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] divider,
  output logic chop
);

  // ==========================================================
  // Chopping carrier
  logic [W-1:0] cnt;

  // Toggles every divider+1 cycles: f = fclk / (2*(divider+1))
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      chop <= 1'b0;
    end else if (cnt >= divider) begin
      cnt <= '0;
      chop <= ~chop;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

//--- hw/tpc_pwm.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// Function
// - Six outputs: high and low drive for phases A, B, C.
// - Period, dead time, minimum pulse width each have own register.
// - One duty register per phase sets that pair's duty.
// - Each output has its own enable bit in segment register.
// - Per-phase crossover bit swaps high and low signals.
// - Eight-bit gate field sets chopping frequency.
// - Separate chop enables for high side and low side.
// - Single update: new values taken once per period.
// - Double update: new values also taken at period midpoint.
// - One mode bit selects single or double update.
// - Sync pulse at period start, and at midpoint in double mode.
// - Sync pulse width comes from sync width register.
// - Trip pin low forces all outputs off without a clock.
// - Any current-sense comparator trip starts a shutdown.
// - Hardware shutdown paths are unclocked.
// - Writing the software trip register shuts the PWM down.
// - Status shows trip pin level, and current half period in double mode.
// - Three complementary centred pairs with dead time inserted.
// - Shutdown sources combine and reset the timing unit.
// - Logic runs at instruction rate, shown on clock output.
// - Interrupt pulses on each sync and on any shutdown.
// - Mode bit 6: clear single, set double; cleared at reset.
// - Status bit 3 is 0 first half, 1 second half in double mode; held at 0 in single mode.
// - Sync lasts width+1 cycles; width resets to 0x27.
// - Sync rising edge latches configuration, duty and segment.
module tpc_pwm (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [tpc_pkg::AW-1:0] regAddr,
  input wire logic [tpc_pkg::DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [tpc_pkg::DW-1:0] regRdata,
  input wire logic tripInputN,
  input wire logic [2:0] senseTripHi,
  input wire logic [2:0] senseTripLo,
  output logic phaseAHigh,
  output logic phaseBHigh,
  output logic phaseCHigh,
  output logic phaseALow,
  output logic phaseBLow,
  output logic phaseCLow,
  output logic syncPulse,
  output logic syncIrq,
  output logic tripIrq,
  output logic instructionClockOut
);

  // ==========================================================
  // Unclocked shutdown path
  logic killN;
  logic rstOut;

  // Trip pin or any comparator; no clock involved
  assign killN = tripInputN & ~(|senseTripHi) & ~(|senseTripLo);
  assign rstOut = nrst & killN;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] tripSync;
  logic [1:0] killSync;

  // Two stages each before the clocked logic reads the pin levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tripSync <= 2'b11;
      killSync <= 2'b11;
    end else begin
      tripSync <= {tripSync[0], tripInputN};
      killSync <= {killSync[0], killN};
    end
  end

  // ==========================================================
  // Software registers
  logic [15:0] periodReg;
  logic [tpc_pkg::DEAD_W-1:0] deadReg;
  logic [15:0] pdelReg;
  logic [2:0][15:0] dutyReg;
  logic [tpc_pkg::SEG_W-1:0] segReg;
  logic [tpc_pkg::GATE_W-1:0] gateReg;
  logic modeDouble;
  logic [tpc_pkg::SYNCW_W-1:0] syncwReg;
  logic swTripWr;
  logic enableWr;

  assign swTripWr = regWr && regAddr == tpc_pkg::OFF_SWTRIP;
  assign enableWr = regWr && regAddr == tpc_pkg::OFF_CTRL
    && regWdata[tpc_pkg::CTRL_EN_BIT];

  // Register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodReg <= tpc_pkg::RST_PERIOD;
      deadReg <= tpc_pkg::RST_DEAD[tpc_pkg::DEAD_W-1:0];
      pdelReg <= tpc_pkg::RST_PDEL;
      dutyReg <= {3{tpc_pkg::RST_DUTY}};
      segReg <= tpc_pkg::RST_SEG[tpc_pkg::SEG_W-1:0];
      gateReg <= tpc_pkg::RST_GATE[tpc_pkg::GATE_W-1:0];
      modeDouble <= 1'b0;
      syncwReg <= tpc_pkg::RST_SYNCW[tpc_pkg::SYNCW_W-1:0];
    end else if (regWr) begin
      case (regAddr)
        tpc_pkg::OFF_PERIOD: periodReg <= regWdata;
        tpc_pkg::OFF_DEAD: deadReg <= regWdata[tpc_pkg::DEAD_W-1:0];
        tpc_pkg::OFF_PDEL: pdelReg <= regWdata;
        tpc_pkg::OFF_DUTYA: dutyReg[0] <= regWdata;
        tpc_pkg::OFF_DUTYB: dutyReg[1] <= regWdata;
        tpc_pkg::OFF_DUTYC: dutyReg[2] <= regWdata;
        tpc_pkg::OFF_SEG: segReg <= regWdata[tpc_pkg::SEG_W-1:0];
        tpc_pkg::OFF_GATE: gateReg <= regWdata[tpc_pkg::GATE_W-1:0];
        tpc_pkg::OFF_MODE: begin
          modeDouble <= regWdata[tpc_pkg::MODE_DOUBLE_BIT];
        end
        tpc_pkg::OFF_SYNCW: begin
          syncwReg <= regWdata[tpc_pkg::SYNCW_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Shutdown controller
  logic tripped;
  logic trippedD;

  // Set asynchronously by hardware, or by software; set beats clear
  always_ff @(posedge clk or negedge rstOut) begin
    if (!rstOut) begin
      tripped <= 1'b1;
    end else if (swTripWr || !killSync[1]) begin
      tripped <= 1'b1;
    end else if (enableWr) begin
      tripped <= 1'b0;
    end
  end

  // Shutdown interrupt on each new shutdown
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trippedD <= 1'b1;
      tripIrq <= 1'b0;
    end else begin
      trippedD <= tripped;
      tripIrq <= tripped & ~trippedD;
    end
  end

  // ==========================================================
  // Timing unit counter
  tpc_pkg::tpc_cfg_t cfg;
  logic [15:0] halfCnt;
  logic half;
  logic lastTick;
  logic syncStart;

  assign lastTick = halfCnt + 16'h0001 >= cfg.period;
  // Period start always; midpoint only in double mode
  assign syncStart = !tripped && lastTick
    && (half || modeDouble);

  // Half-period up counter, held at zero during shutdown
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      halfCnt <= '0;
      half <= 1'b0;
    end else if (tripped) begin
      halfCnt <= '0;
      half <= 1'b0;
    end else if (lastTick) begin
      halfCnt <= '0;
      half <= ~half;
    end else begin
      halfCnt <= halfCnt + 16'h0001;
    end
  end

  // Working set loaded at each sync and while shut down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg.period <= tpc_pkg::RST_PERIOD;
      cfg.dead <= tpc_pkg::RST_DEAD[tpc_pkg::DEAD_W-1:0];
      cfg.pdel <= tpc_pkg::RST_PDEL;
      cfg.syncw <= tpc_pkg::RST_SYNCW[tpc_pkg::SYNCW_W-1:0];
      cfg.duty <= {3{tpc_pkg::RST_DUTY}};
      cfg.seg <= tpc_pkg::RST_SEG[tpc_pkg::SEG_W-1:0];
    end else if (syncStart || tripped) begin
      cfg.period <= periodReg;
      cfg.dead <= deadReg;
      cfg.pdel <= pdelReg;
      cfg.syncw <= syncwReg;
      cfg.duty <= dutyReg;
      cfg.seg <= segReg;
    end
  end

  // ==========================================================
  // Sync pulse
  logic [tpc_pkg::SYNCW_W-1:0] syncRem;

  // High for width+1 cycles from the start of a half period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncRem <= '0;
      syncPulse <= 1'b0;
      syncIrq <= 1'b0;
    end else begin
      syncPulse <= syncStart || syncRem != '0;
      syncIrq <= syncStart;
      if (syncStart) begin
        syncRem <= syncwReg;
      end else if (syncRem != '0) begin
        syncRem <= syncRem - 1'b1;
      end
    end
  end

  // ==========================================================
  // Gate chopping carrier
  logic chop;

  tpc_gate_chop #(
    .W(8)
  ) u_chop (
    .clk(clk),
    .nrst(nrst),
    .divider(gateReg[7:0]),
    .chop(chop)
  );

  // ==========================================================
  // Per-phase waveform, output control and mixing
  logic [2:0] nextHi;
  logic [2:0] nextLo;

  for (genvar i = 0; i < 3; i++) begin : g_ph
    wire signed [17:0] cS = 18'(halfCnt);
    wire signed [17:0] pS = 18'(cfg.period);
    wire signed [17:0] dS = 18'(cfg.duty[i]);
    wire signed [17:0] tS = 18'(cfg.dead);
    wire signed [17:0] mS = 18'(cfg.pdel);
    wire signed [17:0] hiW = dS - tS;
    wire signed [17:0] loW = pS - dS - tS;
    wire hiKeep = hiW >= mS && hiW > 18'sh00000;
    wire loKeep = loW >= mS && loW > 18'sh00000;
    // Centred edges, each pulled in by the dead time
    wire hiRaw = hiKeep && (half ? cS < hiW : cS >= pS - hiW);
    wire loRaw = loKeep && (half ? cS >= pS - loW : cS < loW);
    wire xo = cfg.seg[tpc_pkg::SEG_XOVER_LSB + i];
    wire hiSel = xo ? loRaw : hiRaw;
    wire loSel = xo ? hiRaw : loRaw;
    wire hiChop = ~gateReg[tpc_pkg::GATE_HI_BIT] | chop;
    wire loChop = ~gateReg[tpc_pkg::GATE_LO_BIT] | chop;
    assign nextHi[i] = ~tripped & cfg.seg[2*i] & hiSel & hiChop;
    assign nextLo[i] = ~tripped & cfg.seg[2*i+1] & loSel & loChop;
  end

  // ==========================================================
  // Output stage, cleared without a clock by any hardware trip
  logic [2:0] hiDrv;
  logic [2:0] loDrv;

  always_ff @(posedge clk or negedge rstOut) begin
    if (!rstOut) begin
      hiDrv <= '0;
      loDrv <= '0;
    end else begin
      hiDrv <= nextHi;
      loDrv <= nextLo;
    end
  end

  // Pins straight from the output flops
  assign phaseAHigh = hiDrv[0];
  assign phaseBHigh = hiDrv[1];
  assign phaseCHigh = hiDrv[2];
  assign phaseALow = loDrv[0];
  assign phaseBLow = loDrv[1];
  assign phaseCLow = loDrv[2];

  // ==========================================================
  // Instruction clock indicator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instructionClockOut <= 1'b0;
    end else begin
      instructionClockOut <= ~instructionClockOut;
    end
  end

  // ==========================================================
  // Read port, data in the cycle after the strobe
  logic [15:0] readVal;

  always_comb begin
    readVal = '0;
    case (regAddr)
      tpc_pkg::OFF_PERIOD: readVal = periodReg;
      tpc_pkg::OFF_DEAD: readVal = 16'(deadReg);
      tpc_pkg::OFF_PDEL: readVal = pdelReg;
      tpc_pkg::OFF_DUTYA: readVal = dutyReg[0];
      tpc_pkg::OFF_DUTYB: readVal = dutyReg[1];
      tpc_pkg::OFF_DUTYC: readVal = dutyReg[2];
      tpc_pkg::OFF_SEG: readVal = 16'(segReg);
      tpc_pkg::OFF_GATE: readVal = 16'(gateReg);
      tpc_pkg::OFF_MODE: readVal[tpc_pkg::MODE_DOUBLE_BIT] = modeDouble;
      tpc_pkg::OFF_SYNCW: readVal = 16'(syncwReg);
      tpc_pkg::OFF_STATUS: begin
        readVal[tpc_pkg::STAT_TRIP_BIT] = tripSync[1];
        readVal[tpc_pkg::STAT_SHUT_BIT] = tripped;
        readVal[tpc_pkg::STAT_HALF_BIT] = half & modeDouble;
      end
      default: readVal = '0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? readVal : '0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic [8:0] syncLen;

  // Length of the current sync pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncLen <= '0;
    end else begin
      syncLen <= syncPulse ? syncLen + 9'h001 : 9'h000;
    end
  end

  sync_width_a: assert property ($fell(syncPulse) |->
    syncLen == 9'($past(cfg.syncw, 2)) + 9'h001)
    else $error("sync pulse width wrong");

  trip_off_a: assert property (!tripSync[1] |->
    hiDrv == '0 && loDrv == '0)
    else $error("outputs on while trip pin low");

  pair_excl_a: assert property (!(|(hiDrv & loDrv)))
    else $error("both drives of a pair on");

  sync_place_a: assert property ($rose(syncPulse) |->
    halfCnt == 16'h0000 && (modeDouble || !half))
    else $error("sync pulse at wrong point");

  status_half_a: assert property (
    regRd && regAddr == tpc_pkg::OFF_STATUS |=>
    regRdata[tpc_pkg::STAT_HALF_BIT] == $past(half && modeDouble))
    else $error("half status bit wrong");

  sw_trip_a: assert property (
    regWr && regAddr == tpc_pkg::OFF_SWTRIP |=>
    tripped ##1 (hiDrv == '0 && loDrv == '0))
    else $error("software trip not honoured");

  trip_irq_a: assert property ($rose(tripped) |=> tripIrq)
    else $error("no shutdown interrupt");

  sync_irq_a: assert property ($rose(syncPulse) |-> syncIrq)
    else $error("no sync interrupt");

  cfg_latch_a: assert property (syncStart |=>
    cfg.period == $past(periodReg) && cfg.duty == $past(dutyReg))
    else $error("configuration not latched at sync");

  reenable_a: assert property ($fell(tripped) |->
    $past(enableWr) && $past(killSync[1]))
    else $error("shutdown left without enable");

endmodule

//--- tb/tpc_inverter_model.sv
`timescale 1ns/1ns
// ====================
// Gate driver model: counts cross conduction and phase A off gaps
module tpc_inverter_model (
  input wire logic clk,
  input wire logic clear,
  input wire logic [5:0] gates,
  output int shoot,
  output int minGap
);
  int gap;

  // Both switches of one leg on would short the link
  always @(posedge clk) begin
    if (clear) begin
      shoot <= 0;
      minGap <= 9999;
      gap <= -10000;
    end else begin
      // An unknown gate level counts as a possible short
      if ((&gates[0+:2]) !== 1'b0 || (&gates[2+:2]) !== 1'b0
          || (&gates[4+:2]) !== 1'b0) begin
        shoot <= shoot + 1;
      end
      if (gates[1:0] == 2'h0) begin
        gap <= gap + 1;
      end else begin
        if (gap > 0 && gap < minGap) begin
          minGap <= gap;
        end
        gap <= 0;
      end
    end
  end
endmodule

//--- tb/three_phase_pwm_controller_tb.sv
`timescale 1ns/1ns
// ====================
// Self-checking bench for the PWM controller
module three_phase_pwm_controller_tb;
  logic clk, nrst, regWr, regRd, tripN, clear;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, rv, wd;
  logic [2:0] senseHi, senseLo;
  logic [5:0] pins;
  logic syncPulse, syncIrq, tripIrq, instruction_clock_out;
  int nMismatch = 0;
  int checksDone = 0;
  int cyc = 0;
  int shoot, minGap, nSync, nIrq, nTog, nTrip, P, dd, pd, sw, seg;
  int cnt[6];
  int duty[3];
  int mdl[16];
  int msk[10];

  tpc_pwm dut_u (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .tripInputN(tripN), .senseTripHi(senseHi),
    .senseTripLo(senseLo), .phaseAHigh(pins[0]), .phaseALow(pins[1]),
    .phaseBHigh(pins[2]), .phaseBLow(pins[3]), .phaseCHigh(pins[4]),
    .phaseCLow(pins[5]), .syncPulse(syncPulse), .syncIrq(syncIrq),
    .tripIrq(tripIrq), .instructionClockOut(instruction_clock_out));

  tpc_inverter_model inv_u (.clk(clk), .clear(clear), .gates(pins),
    .shoot(shoot), .minGap(minGap));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cut a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nMismatch++;
      results();
    end
  end

  // ====================
  // Checking and bus tasks
  task automatic results();
    if (nMismatch == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    chk(16'(got), 16'(exp));
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rv = regRdata;
  endtask

  task automatic setup(input int p, d, q, s, g, m, a, b, c);
    P = p;
    dd = d;
    pd = q;
    sw = s;
    seg = g;
    duty = '{a, b, c};
    wr(4'h0, 16'(p));
    wr(4'h1, 16'(d));
    wr(4'h2, 16'(q));
    wr(4'h3, 16'(a));
    wr(4'h4, 16'(b));
    wr(4'h5, 16'(c));
    wr(4'h6, 16'(g));
    wr(4'h7, 16'h0000);
    wr(4'h8, 16'(m));
    wr(4'h9, 16'(s));
  endtask

  task automatic waitSync();
    int n = 0;
    @(negedge clk);
    while (syncIrq !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) chkn(0, 1);
  endtask

  // Count output activity over one full period from a sync edge
  task automatic meas();
    logic prev;
    waitSync();
    waitSync();
    cnt = '{default: 0};
    nSync = 0;
    nIrq = 0;
    nTog = 0;
    prev = instruction_clock_out;
    clear <= 1'b1;
    repeat (2 * P) begin
      for (int i = 0; i < 6; i++) cnt[i] += (pins[i] !== 1'b0);
      nSync += (syncPulse !== 1'b0);
      nIrq += (syncIrq !== 1'b0);
      nTog += (instruction_clock_out !== prev);
      prev = instruction_clock_out;
      @(negedge clk);
      clear <= 1'b0;
    end
  endtask

  // Reference on time over one full period (twice the half-period width), after deletion
  function automatic int ons(input int w);
    return (w <= 0 || w < pd) ? 0 : 2 * w;
  endfunction

  task automatic check(input int syncs);
    int h, l;
    int e[6];
    for (int k = 0; k < 3; k++) begin
      h = ons(duty[k] - dd);
      l = ons(P - duty[k] - dd);
      e[2*k] = seg[6+k] ? l : h;
      e[2*k+1] = seg[6+k] ? h : l;
    end
    for (int k = 0; k < 6; k++) chkn(cnt[k], seg[k] ? e[k] : 0);
    chkn(nSync, syncs * (sw + 1));
    chkn(nIrq, syncs);
    chkn(nTog, 2 * P - 1);
    chkn(shoot, 0);
    if (pd == 0) chkn(minGap, 2 * dd);
  endtask

  // ====================
  // Main sequence
  initial begin
    void'($urandom(45574));
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    tripN = 1'b1;
    senseHi = 3'h0;
    senseLo = 3'h0;
    clear = 1'b1;
    mdl = '{16'h03E8, 0, 0, 0, 0, 0, 16'h003F, 0, 0, 16'h0027, 0,
      16'h0003, 0, 0, 0, 0};
    msk = '{16'hFFFF, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'h01FF, 16'h03FF, 16'h0040, 16'h00FF};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 12; a++) begin
      if (a != 10) begin
        rd(4'(a));
        chk(rv, 16'(mdl[a]));
      end
    end
    for (int a = 0; a < 10; a++) begin
      wd = 16'($urandom);
      if (a == 8) wd &= 16'h0040;
      wr(4'(a), wd);
      rd(4'(a));
      chk(rv, wd & 16'(msk[a]));
    end
    wr(4'hD, 16'hFFFF);
    rd(4'hD);
    chk(rv, 16'h0000);
    rd(4'hF);
    chk(rv, 16'h0000);
    setup(40, 3, 0, 3, 16'h01FF, 0, 25, 5 + $urandom % 25, 30);
    repeat (3) @(negedge clk);
    chk(16'(pins), 16'h0000);
    wr(4'hC, 16'h0001);
    meas();
    check(1);
    rd(4'hB);
    chk(rv, 16'h0001);
    // Chopping on one side leaves the other side whole
    setup(40, 3, 0, 3, 16'h003F, 0, 25, 20, 20);
    for (int k = 0; k < 2; k++) begin
      wr(4'h7, k ? 16'h0201 : 16'h0101);
      meas();
      chkn(cnt[k] > 0 && cnt[k] < (k ? 24 : 44), 1);
      chkn(cnt[1-k], k ? 44 : 24);
    end
    setup(40, 3, 15, 7, 16'h003B, 0, 30, 20, 10);
    meas();
    check(1);
    wr(4'hA, 16'h0001);
    nTrip = 0;
    repeat (3) begin
      @(negedge clk);
      nTrip += (tripIrq !== 1'b0);
    end
    chk(16'(pins), 16'h0000);
    chkn(nTrip, 1);
    rd(4'hB);
    chk(rv, 16'h0003);
    setup(40, 3, 0, 3, 16'h003F, 16'h0040, 25, 15, 35);
    wr(4'hC, 16'h0001);
    meas();
    check(2);
    waitSync();
    rd(4'hB);
    wd = rv;
    waitSync();
    rd(4'hB);
    chk(rv ^ wd, 16'h0008);
    // Trip pin, then each comparator, each after an enable and followed by 80 cycles with outputs held off
    for (int i = 0; i < 7; i++) begin
      wr(4'hC, 16'h0001);
      repeat (50) @(posedge clk);
      tripN <= (i != 0);
      senseHi <= (i > 0 && i < 4) ? 3'(1 << (i - 1)) : 3'h0;
      senseLo <= (i > 3) ? 3'(1 << (i - 4)) : 3'h0;
      #2;
      chk(16'(pins), 16'h0000);
      nTrip = 0;
      repeat (3) begin
        @(negedge clk);
        nTrip += (tripIrq !== 1'b0);
      end
      chkn(nTrip, 1);
      if (i == 0) begin
        rd(4'hB);
        chk(rv, 16'h0002);
      end
      @(posedge clk);
      tripN <= 1'b1;
      senseHi <= 3'h0;
      senseLo <= 3'h0;
      nTog = 0;
      repeat (80) begin
        @(negedge clk);
        nTog += (pins !== 6'h00);
      end
      chkn(nTog, 0);
    end
    results();
  end
endmodule
